// ===== pkg/fault_limit_map.vh
// command codes, field positions, reset values and timing for the fault supervisor
`ifndef FAULT_LIMIT_MAP_VH
`define FAULT_LIMIT_MAP_VH

`define CMD_UV_THRESHOLD   8'h44
`define CMD_UV_REACTION    8'h45
`define CMD_OC_THRESHOLD   8'h46
`define CMD_UC_THRESHOLD   8'h4b
`define CMD_OT_THRESHOLD   8'h4f

`define REACT_MODE_HI      7
`define REACT_MODE_LO      6
`define REACT_RETRY_HI     5
`define REACT_RETRY_LO     3
`define REACT_TIME_HI      2
`define REACT_TIME_LO      0

`define MODE_DISABLE_RETRY 2'h2
`define RETRY_NEVER        3'h0
`define RETRY_FOREVER      3'h7

`define UV_REACTION_RST    8'h80
`define UV_THRESHOLD_RST   16'h0000
`define OC_THRESHOLD_RST   16'hffff
`define UC_THRESHOLD_RST   16'h0000
`define OT_THRESHOLD_RST   16'hffff

`define STAT_UV            0
`define STAT_OC            1
`define STAT_UC            2
`define STAT_OT            3

`define BUS_ADDR_DEFAULT   7'h2a
`define RETRY_STEP_MS      35
`define CORE_CLK_KHZ       250000

`endif

// ===== hdl/pin_filter.v
// three-stage pin synchroniser with agreement filter for the bus pins
`timescale 1ns/1ps
module pin_filter
(
  input  wire       CORE_CLK,
  input  wire       RST,
  input  wire [1:0] PIN_IN,
  output reg  [1:0] PIN_CLEAN
);

  reg [1:0] stage1;
  reg [1:0] stage2;
  reg [1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_pin
      // idle bus level is high, so reset to high
      always @(posedge CORE_CLK)
      begin
        if (RST)
        begin
          stage1[i]    <= 1'b1;
          stage2[i]    <= 1'b1;
          stage3[i]    <= 1'b1;
          PIN_CLEAN[i] <= 1'b1;
        end
        else
        begin
          stage1[i] <= PIN_IN[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // only stages two and three vote, stage one feeds stage two alone
          if (stage2[i] == stage3[i])
            PIN_CLEAN[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule // pin_filter

// ===== hdl/output_fault_limit_response.v
// fault supervisor with bus command registers for a point-of-load regulator
`timescale 1ns/1ps
`include "fault_limit_map.vh"
module output_fault_limit_response
#(
  parameter [6:0]  BUS_ADDR          = `BUS_ADDR_DEFAULT,
  parameter [31:0] RETRY_STEP_CYCLES = `RETRY_STEP_MS * `CORE_CLK_KHZ
)
(
  input  wire        CORE_CLK,
  input  wire        RST,
  input  wire        BUS_CLK,
  input  wire        BUS_DATA_IN,
  output wire        BUS_DATA_OUT,
  output reg         BUS_DATA_OE,
  input  wire        OUTPUT_ON_CMD,
  input  wire        FAULT_CLEAR,
  input  wire        RAMP_DONE,
  input  wire [15:0] VOUT_SENSE,
  input  wire [15:0] PHASE_A_PEAK,
  input  wire [15:0] PHASE_B_PEAK,
  input  wire [15:0] TEMPERATURE,
  output wire        OUTPUT_ENABLE,
  output reg         OUTPUT_GOOD_INDICATION,
  output reg         ALERT_LINE_N,
  output reg  [3:0]  FAULT_STATUS
);

  localparam [5:0] B_IDLE   = 6'b000001;
  localparam [5:0] B_ADDR   = 6'b000010;
  localparam [5:0] B_CMD    = 6'b000100;
  localparam [5:0] B_WDATA  = 6'b001000;
  localparam [5:0] B_RDATA  = 6'b010000;
  localparam [5:0] B_IGNORE = 6'b100000;

  localparam [3:0] ST_OFF   = 4'b0001;
  localparam [3:0] ST_RUN   = 4'b0010;
  localparam [3:0] ST_WAIT  = 4'b0100;
  localparam [3:0] ST_LATCH = 4'b1000;

  wire [1:0]  pins_clean;
  reg         scl_prev;
  reg         sda_prev;
  reg  [5:0]  bus_state;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shift;
  reg  [7:0]  cmd;
  reg  [7:0]  low_byte;
  reg         byte_idx;
  reg  [7:0]  uv_reaction;
  reg  [15:0] uv_threshold;
  reg  [15:0] oc_threshold;
  reg  [15:0] uc_threshold;
  reg  [15:0] ot_threshold;
  reg  [3:0]  state;
  reg  [2:0]  attempts;
  reg  [2:0]  steps_left;
  reg  [31:0] step_cnt;
  wire        scl;
  wire        sda;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_seen;
  wire        stop_seen;
  wire [15:0] rd_word;
  wire [7:0]  tx_byte;
  wire [1:0]  react_mode;
  wire [2:0]  retry_count;
  wire [2:0]  retry_time;
  wire        uv_event;
  wire        oc_event;
  wire        uc_event;
  wire        ot_event;
  wire        other_fault;
  wire [3:0]  next_status;

  // 0 unknown, 1 byte, 2 word
  function [1:0] cmd_width;
    input [7:0] code;
    begin
      if (code == `CMD_UV_REACTION)
        cmd_width = 2'd1;
      else if (code == `CMD_UV_THRESHOLD || code == `CMD_OC_THRESHOLD)
        cmd_width = 2'd2;
      else if (code == `CMD_UC_THRESHOLD || code == `CMD_OT_THRESHOLD)
        cmd_width = 2'd2;
      else
        cmd_width = 2'd0;
    end
  endfunction

  function [15:0] read_word;
    input [7:0] code;
    begin
      if (code == `CMD_UV_REACTION)
        read_word = {8'hff, uv_reaction};
      else if (code == `CMD_UV_THRESHOLD)
        read_word = uv_threshold;
      else if (code == `CMD_OC_THRESHOLD)
        read_word = oc_threshold;
      else if (code == `CMD_UC_THRESHOLD)
        read_word = uc_threshold;
      else if (code == `CMD_OT_THRESHOLD)
        read_word = ot_threshold;
      else
        read_word = 16'hffff;
    end
  endfunction

  pin_filter u_pin_filter
  (
    .CORE_CLK  (CORE_CLK),
    .RST       (RST),
    .PIN_IN    ({BUS_CLK, BUS_DATA_IN}),
    .PIN_CLEAN (pins_clean)
  );

  assign scl          = pins_clean[1];
  assign sda          = pins_clean[0];
  assign scl_rise     = scl & ~scl_prev;
  assign scl_fall     = ~scl & scl_prev;
  assign start_seen   = scl & scl_prev & sda_prev & ~sda;
  assign stop_seen    = scl & scl_prev & ~sda_prev & sda;
  // open drain: only ever pulls low
  assign BUS_DATA_OUT = 1'b0;
  // byte past the one-byte register reads as all ones, a word register wraps back to its low byte
  assign rd_word      = read_word(cmd);
  assign tx_byte      = byte_idx ? rd_word[15:8] : rd_word[7:0];

  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      scl_prev     <= 1'b1;
      sda_prev     <= 1'b1;
      bus_state    <= B_IDLE;
      bit_cnt      <= 4'h0;
      shift        <= 8'h00;
      cmd          <= 8'h00;
      low_byte     <= 8'h00;
      byte_idx     <= 1'b0;
      BUS_DATA_OE  <= 1'b0;
      uv_reaction  <= `UV_REACTION_RST;
      uv_threshold <= `UV_THRESHOLD_RST;
      oc_threshold <= `OC_THRESHOLD_RST;
      uc_threshold <= `UC_THRESHOLD_RST;
      ot_threshold <= `OT_THRESHOLD_RST;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda;
      if (start_seen)
      begin
        bus_state   <= B_ADDR;
        bit_cnt     <= 4'h0;
        BUS_DATA_OE <= 1'b0;
      end
      else if (stop_seen)
      begin
        bus_state   <= B_IDLE;
        bit_cnt     <= 4'h0;
        BUS_DATA_OE <= 1'b0;
      end
      else if (scl_rise && bus_state != B_IDLE)
      begin
        if (bit_cnt != 4'h8)
        begin
          shift   <= {shift[6:0], sda};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else
        begin
          bit_cnt <= 4'h0;
          if (bus_state == B_RDATA)
          begin
            // host not-acknowledge ends the read
            if (sda)
              bus_state <= B_IGNORE;
            else
              byte_idx <= ~byte_idx;
          end
        end
      end
      else if (scl_fall && bus_state != B_IDLE)
      begin
        BUS_DATA_OE <= 1'b0;
        if (bit_cnt == 4'h8)
        begin
          case (bus_state)
            B_ADDR:
            begin
              byte_idx <= shift[0]; // read: address ack rise flips it to low byte
              if (shift[7:1] == BUS_ADDR)
              begin
                BUS_DATA_OE <= 1'b1;
                bus_state   <= shift[0] ? B_RDATA : B_CMD;
              end
              else
                bus_state <= B_IGNORE;
            end
            B_CMD:
            begin
              cmd <= shift;
              if (cmd_width(shift) != 2'd0)
              begin
                BUS_DATA_OE <= 1'b1;
                bus_state   <= B_WDATA;
              end
              else
                bus_state <= B_IGNORE;
            end
            B_WDATA:
            begin
              byte_idx <= 1'b1;
              if (!byte_idx)
              begin
                BUS_DATA_OE <= 1'b1;
                low_byte    <= shift;
                if (cmd_width(cmd) == 2'd1)
                  uv_reaction <= shift;
              end
              else if (cmd_width(cmd) == 2'd2)
              begin
                BUS_DATA_OE <= 1'b1;
                // word commits whole on the high byte, low byte held until then
                if (cmd == `CMD_UV_THRESHOLD)
                  uv_threshold <= {shift, low_byte};
                else if (cmd == `CMD_OC_THRESHOLD)
                  oc_threshold <= {shift, low_byte};
                else if (cmd == `CMD_UC_THRESHOLD)
                  uc_threshold <= {shift, low_byte};
                else
                  ot_threshold <= {shift, low_byte};
              end
            end
            default:
            begin
            end
          endcase
        end
        else if (bus_state == B_RDATA)
          BUS_DATA_OE <= ~tx_byte[3'd7 - bit_cnt[2:0]];
      end
    end
  end

  assign react_mode  = uv_reaction[`REACT_MODE_HI:`REACT_MODE_LO];
  assign retry_count = uv_reaction[`REACT_RETRY_HI:`REACT_RETRY_LO];
  assign retry_time  = uv_reaction[`REACT_TIME_HI:`REACT_TIME_LO];
  // voltage and under-current checks are blanked while the output ramps
  assign uv_event    = (state == ST_RUN) & RAMP_DONE & (VOUT_SENSE < uv_threshold);
  assign oc_event    = (state == ST_RUN) & ((PHASE_A_PEAK > oc_threshold) |
                       (PHASE_B_PEAK > oc_threshold));
  assign uc_event    = (state == ST_RUN) & RAMP_DONE & ((PHASE_A_PEAK < uc_threshold) |
                       (PHASE_B_PEAK < uc_threshold));
  assign ot_event    = TEMPERATURE > ot_threshold;
  assign other_fault = oc_event | uc_event | ot_event;
  // a new event beats a clear in the same cycle
  assign next_status = (FAULT_STATUS & ~{4{FAULT_CLEAR}}) |
                       {ot_event, uc_event, oc_event, uv_event};
  assign OUTPUT_ENABLE = state[1];

  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state                  <= ST_OFF;
      attempts               <= 3'h0;
      steps_left             <= 3'h0;
      step_cnt               <= 32'h0;
      FAULT_STATUS           <= 4'h0;
      ALERT_LINE_N           <= 1'b1;
      OUTPUT_GOOD_INDICATION <= 1'b0;
    end
    else
    begin
      FAULT_STATUS <= next_status;
      ALERT_LINE_N <= ~(|next_status);
      OUTPUT_GOOD_INDICATION <= (state == ST_RUN) & RAMP_DONE &
                                (VOUT_SENSE >= uv_threshold);
      case (state)
        ST_OFF:
        begin
          attempts <= 3'h0;
          if (OUTPUT_ON_CMD && !ot_event)
            state <= ST_RUN;
        end
        ST_RUN:
        begin
          if (!OUTPUT_ON_CMD)
            state <= ST_OFF;
          else if (other_fault)
            state <= ST_LATCH;
          else if (uv_event && react_mode == `MODE_DISABLE_RETRY)
          begin
            // output drops on the very next edge, no delay
            if (retry_count == `RETRY_NEVER)
              state <= ST_LATCH;
            else if (retry_count == `RETRY_FOREVER || attempts < retry_count)
            begin
              state      <= ST_WAIT;
              steps_left <= retry_time;
              step_cnt   <= 32'h0;
            end
            else
              state <= ST_LATCH;
          end
          else if (RAMP_DONE)
            attempts <= 3'h0;
        end
        ST_WAIT:
        begin
          if (!OUTPUT_ON_CMD)
            state <= ST_OFF;
          else if (ot_event)
            state <= ST_LATCH;
          else if (step_cnt == RETRY_STEP_CYCLES - 32'h1)
          begin
            step_cnt <= 32'h0;
            if (steps_left == 3'h0)
            begin
              state <= ST_RUN;
              if (retry_count != `RETRY_FOREVER)
                attempts <= attempts + 3'h1;
            end
            else
              steps_left <= steps_left - 3'h1;
          end
          else
            step_cnt <= step_cnt + 32'h1;
        end
        ST_LATCH:
        begin
          if (!OUTPUT_ON_CMD || FAULT_CLEAR)
            state <= ST_OFF;
        end
        default:
          state <= ST_OFF;
      endcase
    end
  end

endmodule // output_fault_limit_response

// ===== test/fault_limit_monitor.sv
// port assertions for the fault supervisor
`timescale 1ns/1ps
module fault_limit_monitor
(
  input wire logic       CORE_CLK,
  input wire logic       RST,
  input wire logic       BUS_CLK,
  input wire logic       BUS_DATA_OE,
  input wire logic       OUTPUT_ON_CMD,
  input wire logic       FAULT_CLEAR,
  input wire logic       RAMP_DONE,
  input wire logic       OUTPUT_ENABLE,
  input wire logic       OUTPUT_GOOD_INDICATION,
  input wire logic       ALERT_LINE_N,
  input wire logic [3:0] FAULT_STATUS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_alert; ALERT_LINE_N == (FAULT_STATUS == 4'h0); endproperty
  a_alert: assert property (p_alert) else $error("alert mismatch");
  property p_sticky; FAULT_STATUS[0] && !FAULT_CLEAR |=> FAULT_STATUS[0]; endproperty
  a_sticky: assert property (p_sticky) else $error("uv flag lost");
  property p_oc; $rose(FAULT_STATUS[1]) |-> $past(OUTPUT_ENABLE) && !OUTPUT_ENABLE; endproperty
  a_oc: assert property (p_oc) else $error("oc kept on");
  property p_uc; $rose(FAULT_STATUS[2]) |-> $past(RAMP_DONE) && !OUTPUT_ENABLE; endproperty
  a_uc: assert property (p_uc) else $error("uc kept on");
  property p_ot; $rose(FAULT_STATUS[3]) |-> !OUTPUT_ENABLE; endproperty
  a_ot: assert property (p_ot) else $error("ot kept on");
  property p_good; OUTPUT_GOOD_INDICATION |-> $past(OUTPUT_ENABLE) && $past(RAMP_DONE); endproperty
  a_good: assert property (p_good) else $error("good while off");
  property p_cmd_off; !OUTPUT_ON_CMD |=> !OUTPUT_ENABLE; endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("on while off");
  // data may only move while the bus clock is low
  property p_oe; $changed(BUS_DATA_OE) |-> !BUS_CLK; endproperty
  a_oe: assert property (p_oe) else $error("data moved in high");
endmodule // fault_limit_monitor
bind output_fault_limit_response fault_limit_monitor u_mon
(
  .CORE_CLK(CORE_CLK), .RST(RST), .BUS_CLK(BUS_CLK), .BUS_DATA_OE(BUS_DATA_OE),
  .OUTPUT_ON_CMD(OUTPUT_ON_CMD), .FAULT_CLEAR(FAULT_CLEAR), .RAMP_DONE(RAMP_DONE),
  .OUTPUT_ENABLE(OUTPUT_ENABLE), .OUTPUT_GOOD_INDICATION(OUTPUT_GOOD_INDICATION),
  .ALERT_LINE_N(ALERT_LINE_N), .FAULT_STATUS(FAULT_STATUS)
);

// ===== test/bus_host_model.sv
// behavioural bus host driving clock and open-drain data
`timescale 1ns/1ps
module bus_host_model
#(
  parameter [6:0] DEV_ADDR = 7'h2a
)
(
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // data moves well after the fall, clear of the pin filter lag
  task automatic put_bit(input logic b);
    #12 pull = !b;
    #20 scl = 1'b1;
    #32 scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #12 pull = 1'b0;
    #20 scl = 1'b1;
    #16 b = sda;
    #16 scl = 1'b0;
  endtask
  task automatic start_cond;
    #12 pull = 1'b0;
    #20 scl = 1'b1;
    #16 pull = 1'b1;
    #16 scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ok = ok & !a;
  endtask
  // low byte first, as many data bytes as n gives
  task automatic write_reg(input logic [7:0] cmd, input int n, input logic [15:0] v,
                           output logic ok);
    ok = 1'b1;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, ok);
    put_byte(cmd, ok);
    for (int k = 0; k < n; k++) put_byte(v[8*k +: 8], ok);
    #12 pull = 1'b1;
    #20 scl = 1'b1;
    #16 pull = 1'b0;
  endtask
  task automatic read_reg(input logic [7:0] cmd, input int n, output logic [15:0] v);
    logic b;
    logic ok;
    v = 16'h0000;
    write_reg(cmd, 0, 16'h0000, ok);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, ok);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        get_bit(b);
        v[8*k+7-i] = b;
      end
      put_bit(k == n - 1);
    end
    #12 pull = 1'b1;
    #20 scl = 1'b1;
    #16 pull = 1'b0;
  endtask
endmodule // bus_host_model

// ===== test/output_fault_limit_response_test.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
module output_fault_limit_response_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        on_cmd = 1'b0;
  logic        clr = 1'b0;
  logic        ramp = 1'b0;
  logic [15:0] vout = 16'h0300;
  logic [15:0] pha = 16'h0080;
  logic [15:0] phb = 16'h0080;
  logic [15:0] tmp = 16'h0020;
  wire         scl;
  wire         pull;
  wire         dout;
  wire         doe;
  wire         en;
  wire         good;
  wire         alert_n;
  wire  [3:0]  st;
  wire         sda = (doe ? dout : 1'b1) & !pull;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;
  logic        ok;
  logic        prev;
  logic [15:0] v;
  logic [7:0]  cmds [5] = '{8'h44, 8'h45, 8'h46, 8'h4b, 8'h4f};
  logic [15:0] rstv [5] = '{16'h0000, 16'h0080, 16'hffff, 16'h0000, 16'hffff};
  logic [15:0] setv [5] = '{16'h0200, 16'h0089, 16'h0100, 16'h0010, 16'h0050};
  logic [15:0] fa [5] = '{16'h0101, 16'h0080, 16'h0008, 16'h0080, 16'h0080};
  logic [15:0] fb [5] = '{16'h0080, 16'h0101, 16'h0080, 16'h0008, 16'h0080};
  logic [4:0]  fs [5] = '{5'h04, 5'h04, 5'h08, 5'h08, 5'h10};
  always #2 clk = ~clk;
  output_fault_limit_response #(.RETRY_STEP_CYCLES(32'd20)) u_dut
  (
    .CORE_CLK(clk), .RST(rst), .BUS_CLK(scl), .BUS_DATA_IN(sda), .BUS_DATA_OUT(dout),
    .BUS_DATA_OE(doe), .OUTPUT_ON_CMD(on_cmd), .FAULT_CLEAR(clr), .RAMP_DONE(ramp),
    .VOUT_SENSE(vout), .PHASE_A_PEAK(pha), .PHASE_B_PEAK(phb), .TEMPERATURE(tmp),
    .OUTPUT_ENABLE(en), .OUTPUT_GOOD_INDICATION(good), .ALERT_LINE_N(alert_n),
    .FAULT_STATUS(st)
  );
  bus_host_model u_host (.scl(scl), .pull(pull), .sda(sda));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic look;
    @(negedge clk);
  endtask
  task automatic recover;
    cyc(1);
    {pha, phb, tmp, vout} <= {16'h0080, 16'h0080, 16'h0020, 16'h0300};
    on_cmd <= 1'b1;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(12);
    look();
  endtask
  task automatic uv_pulse;
    cyc(1);
    vout <= 16'h0100;
    cyc(1);
    vout <= 16'h0300;
    look();
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // about 13k cycles expected
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  initial
  begin
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    for (int i = 0; i < 5; i++)
    begin
      u_host.read_reg(cmds[i], (i == 1) ? 1 : 2, v);
      check("reset value", rstv[i], v);
      u_host.write_reg(cmds[i], (i == 1) ? 1 : 2, setv[i], ok);
      check("ack", 1, ok);
      u_host.read_reg(cmds[i], (i == 1) ? 1 : 2, v);
      check("read back", setv[i], v);
    end
    u_host.write_reg(8'h47, 1, 16'h0000, ok);
    check("unknown ack", 0, ok);
    $display("test registers done");
    cyc(1);
    ramp <= 1'b1;
    recover();
    check("on and good", 16'h0061, {en, good, st, alert_n});
    check("data out", 16'h0000, dout);
    for (int i = 0; i < 5; i++)
    begin
      cyc(1);
      pha <= fa[i];
      phb <= fb[i];
      tmp <= (i == 4) ? 16'h0051 : 16'h0020;
      cyc(3);
      look();
      check("fault flags", {11'h000, fs[i]}, {en, st, alert_n});
      recover();
    end
    $display("test limits done");
    for (int k = 0; k < 2; k++)
    begin
      uv_pulse();
      check("uv off", 16'h0004, {en, st[0], alert_n, good});
      n = 0;
      while (en !== 1'b1 && n < 400)
      begin
        look();
        n++;
      end
      check("retry delay", 1, n >= 39 && n <= 42);
    end
    cyc(1);
    vout <= 16'h0100;
    cyc(150);
    look();
    check("retries spent", 0, en);
    recover();
    u_host.write_reg(8'h45, 1, 16'h0080, ok);
    uv_pulse();
    cyc(100);
    look();
    check("no retry", 0, en);
    recover();
    check("cleared", 16'h0021, {en, st, alert_n});
    u_host.write_reg(8'h45, 1, 16'h00b8, ok);
    cyc(1);
    vout <= 16'h0100;
    n = 0;
    prev = 1'b1;
    repeat (300)
    begin
      look();
      if (en === 1'b1 && prev === 1'b0) n++;
      prev = en;
    end
    check("endless retry", 1, n > 8);
    cyc(1);
    on_cmd <= 1'b0;
    cyc(30);
    look();
    check("commanded off", 0, en);
    recover();
    u_host.write_reg(8'h45, 1, 16'h0000, ok);
    uv_pulse();
    check("flag only", 16'h0006, {en, st[0], alert_n});
    $display("test retries done");
    give_verdict();
  end
endmodule // output_fault_limit_response_test
